/* rtl/tpg_cfg.svh */
// Register map, field positions and reset values of the PWM timer.
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH
// ----------------------------------------------------------------------------
// Byte addresses on the APB port
// ----------------------------------------------------------------------------
`define TPG_ADDR_STATUS 32'h0001ec80
`define TPG_ADDR_CMD 32'h0001ec84
`define TPG_ADDR_DUTY 32'h0001ec88
`define TPG_ADDR_PERIOD 32'h0001ec8c
`define TPG_ADDR_PRE 32'h0001ec90
`define TPG_ADDR_CNT 32'h0001ec94
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TPG_ST_MATCH0_BIT 0
`define TPG_ST_MATCH1_BIT 1
`define TPG_ST_OUT_BIT 2
`define TPG_CMD_EN_BIT 0
`define TPG_CMD_CLR_BIT 1
`define TPG_PRE_MSB 9
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TPG_RST_DATA 16'h0000
`define TPG_RST_PRE 10'h000
`define TPG_RST_CNT 16'h0000
`endif

/* rtl/tpg_pkg.sv */
// Types shared by the PWM timer design.
package tpg_pkg;
   // Software settings that steer the timer.
   typedef struct packed {
      logic run_enable;
      logic [15:0] duty_value;
      logic [15:0] period_value;
      logic [9:0] prescale_value;
   } tpg_cfg_t;
   // One-tick events of the compare logic.
   typedef struct packed {
      logic match0_event;
      logic match1_event;
   } tpg_evt_t;
endpackage : tpg_pkg

/* rtl/tpg_top.sv */
// PWM timer: APB register slave, prescaler, 16-bit up-counter and compare logic.
//
// Contract
// - A 16-bit up-counter advances once per count-clock tick.
// - Count clock is the bus clock divided by the 10-bit prescale plus one.
// - Counter equal to buffer 0 raises match 0; counting continues.
// - Counter equal to buffer 1 raises match 1, clears counter, reloads both buffers.
// - The PWM output inverts on every tick that raises exactly one match event and no clear.
// - Data writes reach the compare buffers only at match 1 or a clear.
// - Period comes from data 1, duty from data 0; low part (d0+1)/(d1+1).
// - Status shows output at bit 2, match 1 at bit 1, match 0 at bit 0.
// - Command bit 1 clears counter and loads buffers; it reads as zero.
// - Command bit 0 is a read-write run enable.
// - Buffer 0 reload point conflicts; it reloads only with buffer 1 here.
// - Active-low asynchronous reset returns all state to its initial values.
`timescale 1ns/1ns
`default_nettype none
`include "tpg_cfg.svh"
module tpg_top
   import tpg_pkg::*;
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // APB slave port.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Timer outputs.
   output logic o_pwm_output,
   output logic o_match0_irq,
   output logic o_match1_irq
);

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   // True when the address names one of the six mapped registers.
   function automatic logic addr_mapped(input logic [31:0] a);
      addr_mapped = (a == `TPG_ADDR_STATUS) || (a == `TPG_ADDR_CMD) ||
                    (a == `TPG_ADDR_DUTY) || (a == `TPG_ADDR_PERIOD) ||
                    (a == `TPG_ADDR_PRE) || (a == `TPG_ADDR_CNT);
   endfunction : addr_mapped

   // True on the access phase of a write to the given address.
   function automatic logic wr_hit(input logic sel, input logic en, input logic wr,
                                   input logic [31:0] a, input logic [31:0] target);
      wr_hit = sel && en && wr && (a == target);
   endfunction : wr_hit

   // -------------------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------------------
   // Reset asserts at once and releases on the second clock edge.
   logic rst_meta_ff;
   logic rst_n_ff;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // -------------------------------------------------------------------------
   // Register file
   // -------------------------------------------------------------------------
   tpg_cfg_t cfg_ff;
   tpg_cfg_t nxt_cfg;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic clear_cmd;
   logic [15:0] up_counter_ff;
   logic [2:0] status_word;
   logic match0_status_ff;
   logic match1_status_ff;
   logic pwm_output_ff;

   assign status_word = {pwm_output_ff, match1_status_ff, match0_status_ff};
   // The clear is a write strobe only, so it never needs storage.
   assign clear_cmd = wr_hit(i_psel, i_penable, i_pwrite, i_paddr, `TPG_ADDR_CMD) &&
                      i_pwdata[`TPG_CMD_CLR_BIT];

   // Writes land in the access phase; read data is fetched in the setup phase
   // so that it comes from a flip-flop without adding a wait state.
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_prdata = prdata_ff;
      if (wr_hit(i_psel, i_penable, i_pwrite, i_paddr, `TPG_ADDR_CMD)) begin
         nxt_cfg.run_enable = i_pwdata[`TPG_CMD_EN_BIT];
      end
      if (wr_hit(i_psel, i_penable, i_pwrite, i_paddr, `TPG_ADDR_DUTY)) begin
         nxt_cfg.duty_value = i_pwdata[15:0];
      end
      if (wr_hit(i_psel, i_penable, i_pwrite, i_paddr, `TPG_ADDR_PERIOD)) begin
         nxt_cfg.period_value = i_pwdata[15:0];
      end
      if (wr_hit(i_psel, i_penable, i_pwrite, i_paddr, `TPG_ADDR_PRE)) begin
         nxt_cfg.prescale_value = i_pwdata[`TPG_PRE_MSB:0];
      end
      if (i_psel && !i_penable && !i_pwrite) begin
         unique case (i_paddr)
            `TPG_ADDR_STATUS: nxt_prdata = {29'h0, status_word};
            `TPG_ADDR_CMD: nxt_prdata = {31'h0, cfg_ff.run_enable};
            `TPG_ADDR_DUTY: nxt_prdata = {16'h0, cfg_ff.duty_value};
            `TPG_ADDR_PERIOD: nxt_prdata = {16'h0, cfg_ff.period_value};
            `TPG_ADDR_PRE: nxt_prdata = {22'h0, cfg_ff.prescale_value};
            `TPG_ADDR_CNT: nxt_prdata = {16'h0, up_counter_ff};
            default: nxt_prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cfg_ff <= '{run_enable: 1'b0, duty_value: `TPG_RST_DATA,
                     period_value: `TPG_RST_DATA, prescale_value: `TPG_RST_PRE};
         prdata_ff <= 32'h0;
      end else begin
         cfg_ff <= nxt_cfg;
         prdata_ff <= nxt_prdata;
      end
   end

   // The slave never waits; an unmapped address fails in the access phase.
   assign o_prdata = prdata_ff;
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !addr_mapped(i_paddr);

   // -------------------------------------------------------------------------
   // Prescaler, counter and compare
   // -------------------------------------------------------------------------
   logic [9:0] pre_cnt_ff;
   logic [9:0] nxt_pre_cnt;
   logic [15:0] nxt_up_counter;
   logic [15:0] duty_buf_ff;
   logic [15:0] nxt_duty_buf;
   logic [15:0] period_buf_ff;
   logic [15:0] nxt_period_buf;
   logic nxt_pwm_output;
   logic nxt_match0_status;
   logic nxt_match1_status;
   tpg_evt_t evt_ff;
   tpg_evt_t nxt_evt;
   logic tick;

   // A tick closes every prescale+1 bus clocks, and only while running.
   assign tick = cfg_ff.run_enable && (pre_cnt_ff == cfg_ff.prescale_value);

   // Buffer 0 follows buffer 1 and reloads only at match 1 or a clear; reloading
   // it at match 0 would let a duty write shift the edge inside a period.
   always_comb begin
      nxt_pre_cnt = pre_cnt_ff;
      nxt_up_counter = up_counter_ff;
      nxt_duty_buf = duty_buf_ff;
      nxt_period_buf = period_buf_ff;
      nxt_pwm_output = pwm_output_ff;
      nxt_evt = '0;
      nxt_match0_status = match0_status_ff;
      nxt_match1_status = match1_status_ff;
      if (cfg_ff.run_enable) begin
         nxt_pre_cnt = tick ? 10'h000 : pre_cnt_ff + 10'h001;
      end
      if (tick) begin
         nxt_evt.match0_event = (up_counter_ff == duty_buf_ff);
         nxt_evt.match1_event = (up_counter_ff == period_buf_ff);
         if (nxt_evt.match1_event) begin
            nxt_up_counter = `TPG_RST_CNT;
            nxt_duty_buf = cfg_ff.duty_value;
            nxt_period_buf = cfg_ff.period_value;
         end else begin
            nxt_up_counter = up_counter_ff + 16'h0001;
         end
         // Equal buffers give two toggles at once, so the level holds.
         nxt_pwm_output = pwm_output_ff ^ nxt_evt.match0_event ^
                          nxt_evt.match1_event;
      end
      // Status bits are sticky; a clear command drops them unless a match
      // lands in the same cycle, in which case the set wins.
      // A clear also parks the output low, so every run starts in its low phase;
      // otherwise the polarity after a clear would depend on where the last run stopped.
      if (clear_cmd) begin
         nxt_match0_status = 1'b0;
         nxt_match1_status = 1'b0;
         nxt_pwm_output = 1'b0;
         nxt_up_counter = `TPG_RST_CNT;
         nxt_pre_cnt = 10'h000;
         nxt_duty_buf = cfg_ff.duty_value;
         nxt_period_buf = cfg_ff.period_value;
      end
      if (nxt_evt.match0_event) begin
         nxt_match0_status = 1'b1;
      end
      if (nxt_evt.match1_event) begin
         nxt_match1_status = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pre_cnt_ff <= `TPG_RST_PRE;
         up_counter_ff <= `TPG_RST_CNT;
         duty_buf_ff <= `TPG_RST_DATA;
         period_buf_ff <= `TPG_RST_DATA;
         pwm_output_ff <= 1'b0;
         evt_ff <= '0;
         match0_status_ff <= 1'b0;
         match1_status_ff <= 1'b0;
      end else begin
         pre_cnt_ff <= nxt_pre_cnt;
         up_counter_ff <= nxt_up_counter;
         duty_buf_ff <= nxt_duty_buf;
         period_buf_ff <= nxt_period_buf;
         pwm_output_ff <= nxt_pwm_output;
         evt_ff <= nxt_evt;
         match0_status_ff <= nxt_match0_status;
         match1_status_ff <= nxt_match1_status;
      end
   end

   assign o_pwm_output = pwm_output_ff;
   assign o_match0_irq = evt_ff.match0_event;
   assign o_match1_irq = evt_ff.match1_event;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb_main @(posedge i_mclk);
   endclocking
   default disable iff (!rst_n_ff);

   // A plain tick advances the counter by exactly one.
   property p_count_step;
      tick && !clear_cmd && (up_counter_ff != period_buf_ff)
         |=> up_counter_ff == $past(up_counter_ff) + 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter step wrong");

   // With prescale one, ticks are two cycles apart.
   property p_prescale_one;
      tick && !clear_cmd && cfg_ff.prescale_value == 10'h001
         ##1 cfg_ff.prescale_value == 10'h001
         |-> !tick ##1 (tick || $past(clear_cmd) || !cfg_ff.run_enable ||
                        cfg_ff.prescale_value != 10'h001);
   endproperty
   a_prescale_one: assert property (p_prescale_one) else $error("prescale ratio wrong");

   // Match 0 alone leaves the counter running.
   property p_match0_runs;
      o_match0_irq && !o_match1_irq && !$past(clear_cmd) |-> up_counter_ff != 16'h0000;
   endproperty
   a_match0_runs: assert property (p_match0_runs) else $error("match 0 cleared counter");

   // Match 1 clears the counter and loads period data into buffer 1.
   property p_match1_reload;
      o_match1_irq && !$past(clear_cmd)
         |-> up_counter_ff == 16'h0000 && period_buf_ff == $past(cfg_ff.period_value);
   endproperty
   a_match1_reload: assert property (p_match1_reload) else $error("match 1 reload wrong");

   // The output changes exactly when one event fires.
   property p_toggle;
      !$past(clear_cmd) |-> $changed(o_pwm_output) == (o_match0_irq ^ o_match1_irq);
   endproperty
   a_toggle: assert property (p_toggle) else $error("output toggle wrong");

   // Buffers change only after a match 1 tick or a clear.
   property p_buffer_hold;
      $changed(duty_buf_ff) || $changed(period_buf_ff)
         |-> $past(clear_cmd) || o_match1_irq;
   endproperty
   a_buffer_hold: assert property (p_buffer_hold) else $error("buffer changed early");

   // A match event leaves its status bit set.
   property p_status_set;
      (o_match0_irq |-> match0_status_ff) and (o_match1_irq |-> match1_status_ff);
   endproperty
   a_status_set: assert property (p_status_set) else $error("status not set");

   // Clear empties the counter and parks the output low next cycle.
   property p_clear;
      clear_cmd |=> up_counter_ff == 16'h0000 && !o_pwm_output;
   endproperty
   a_clear: assert property (p_clear) else $error("clear command wrong");

   // A command read never shows the clear bit set.
   property p_clear_reads_zero;
      i_psel && !i_penable && !i_pwrite && (i_paddr == `TPG_ADDR_CMD)
         |=> !o_prdata[`TPG_CMD_CLR_BIT];
   endproperty
   a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear bit read set");

   // Disabled timer stays still for two cycles.
   property p_disabled;
      !cfg_ff.run_enable && !clear_cmd ##1 !cfg_ff.run_enable && !clear_cmd
         |=> $stable(up_counter_ff) && !o_match0_irq && !o_match1_irq;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled timer moved");

   // Match 1 events never last two cycles; a zero period legally matches on every tick.
   property p_pulse;
      o_match1_irq && period_buf_ff != 16'h0000 |=> !o_match1_irq;
   endproperty
   a_pulse: assert property (p_pulse) else $error("match pulse too long");

endmodule : tpg_top
`default_nettype wire

/* sim/tpg_apb_master.sv */
// APB master model that reaches the PWM timer registers.
`timescale 1ns/1ns
`default_nettype none
module tpg_apb_master (
   // Clock.
   input wire logic i_mclk,
   // Request side.
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [31:0] o_paddr,
   output logic [31:0] o_pwdata,
   // Answer side.
   input wire logic [31:0] i_prdata,
   input wire logic i_pready,
   input wire logic i_pslverr
);
   // The bus idles deselected from time zero.
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 32'h0;
      o_pwdata = 32'h0;
   end
   // One transfer, launched on falling edges and held until pready is seen high.
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
      @(negedge i_mclk);
      o_psel = 1'b1;
      o_penable = 1'b0;
      o_pwrite = wr;
      o_paddr = addr;
      o_pwdata = wdata;
      @(negedge i_mclk);
      o_penable = 1'b1;
      @(posedge i_mclk);
      while (i_pready !== 1'b1) @(posedge i_mclk);
      rdata = i_prdata;
      err = i_pslverr;
      @(negedge i_mclk);
      o_psel = 1'b0;
      o_penable = 1'b0;
      // Released lines show the inverse so a stale value is never taken for a live one.
      o_pwrite = ~wr;
      o_paddr = ~addr;
      o_pwdata = ~wdata;
   endtask : xfer
endmodule : tpg_apb_master
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking testbench of the PWM timer.
`timescale 1ns/1ns
`default_nettype none
`include "tpg_cfg.svh"
module tb_top;
   logic mclk;
   logic rst_n;
   logic psel, penable, pwrite, pready, pslverr, pwm, irq0, irq1;
   logic [31:0] paddr, pwdata, prdata;
   int bad_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int hi, m0, m1, t;
   int dv[4] = '{0, 0, 5, 5};
   int pv[4] = '{2, 3, 7, 3};
   int qv[4] = '{0, 1, 0, 0};

   tpg_top dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_pwm_output(pwm),
      .o_match0_irq(irq0), .o_match1_irq(irq1));
   tpg_apb_master u_mst (.i_mclk(mclk), .o_psel(psel), .o_penable(penable),
      .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
      .i_pready(pready), .i_pslverr(pslverr));

   // -------------------------------------------------------------------------
   // Checking and bus tasks
   // -------------------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_reg
   task automatic chk_cnt(input string name, input int exp, input int got);
      samples_checked++;
      if (got != exp) begin
         bad_count++;
         $display("[ERR] %s expected %0d seen %0d", name, exp, got);
      end
   endtask : chk_cnt
   task automatic wr(input logic [31:0] addr, input logic [31:0] data);
      logic [31:0] got;
      logic err;
      u_mst.xfer(1'b1, addr, data, got, err);
      chk_reg("write_err", 32'h0, {31'h0, err});
   endtask : wr
   task automatic rd_chk(input string name, input logic [31:0] addr, input logic [31:0] exp,
                         input logic exp_err);
      logic [31:0] got;
      logic err;
      u_mst.xfer(1'b0, addr, 32'h0, got, err);
      chk_reg(name, exp, got);
      chk_reg({name, "_err"}, {31'h0, exp_err}, {31'h0, err});
   endtask : rd_chk
   // Counts high cycles of the output and event pulses over a window.
   task automatic measure(input int n);
      hi = 0;
      m0 = 0;
      m1 = 0;
      repeat (n) begin
         @(negedge mclk);
         hi += int'(pwm === 1'b1);
         m0 += int'(irq0 === 1'b1);
         m1 += int'(irq1 === 1'b1);
      end
   endtask : measure

   // -------------------------------------------------------------------------
   // Clock, timeout and main sequence
   // -------------------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // A hang is cut short well beyond the few hundred cycles the tests need.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      rst_n = 1'b0;
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      rd_chk("status", `TPG_ADDR_STATUS, 32'h0, 1'b0);
      rd_chk("cmd", `TPG_ADDR_CMD, 32'h0, 1'b0);
      rd_chk("duty", `TPG_ADDR_DUTY, 32'h0, 1'b0);
      rd_chk("period", `TPG_ADDR_PERIOD, 32'h0, 1'b0);
      rd_chk("pre", `TPG_ADDR_PRE, 32'h0, 1'b0);
      rd_chk("count", `TPG_ADDR_CNT, 32'h0, 1'b0);
      rd_chk("unmapped", 32'h0001ec98, 32'h0, 1'b1);
      wr(`TPG_ADDR_PRE, 32'hffffffff);
      rd_chk("pre", `TPG_ADDR_PRE, 32'h3ff, 1'b0);
      wr(`TPG_ADDR_DUTY, 32'hffffffff);
      rd_chk("duty", `TPG_ADDR_DUTY, 32'hffff, 1'b0);
      // Each setting runs four whole periods; polarity shows in the high count.
      for (int i = 0; i < 4; i++) begin
         wr(`TPG_ADDR_CMD, 32'h0);
         wr(`TPG_ADDR_DUTY, 32'(dv[i]));
         wr(`TPG_ADDR_PERIOD, 32'(pv[i]));
         wr(`TPG_ADDR_PRE, 32'(qv[i]));
         wr(`TPG_ADDR_CMD, 32'h3);
         rd_chk("cmd", `TPG_ADDR_CMD, 32'h1, 1'b0);
         repeat (20) @(negedge mclk);
         t = (pv[i] + 1) * (qv[i] + 1);
         measure(4 * t);
         if (dv[i] < pv[i]) begin
            chk_cnt("high", 4 * (pv[i] - dv[i]) * (qv[i] + 1), hi);
            chk_cnt("match0", 4, m0);
         end else begin
            chk_cnt("high", 2 * t, hi);
            chk_cnt("match0", 0, m0);
         end
         chk_cnt("match1", 4, m1);
         wr(`TPG_ADDR_CMD, 32'h0);
         rd_chk("status", `TPG_ADDR_STATUS, {29'h0, pwm, 1'b1, dv[i] < pv[i]}, 1'b0);
      end
      // New data written mid-period must wait for the next period end.
      wr(`TPG_ADDR_DUTY, 32'd100);
      wr(`TPG_ADDR_PERIOD, 32'd200);
      wr(`TPG_ADDR_CMD, 32'h3);
      wr(`TPG_ADDR_DUTY, 32'd50);
      wr(`TPG_ADDR_PERIOD, 32'd60);
      measure(70);
      chk_cnt("match0", 0, m0);
      chk_cnt("match1", 0, m1);
      // A clear written together with a disable zeroes the count, and nothing moves after it.
      wr(`TPG_ADDR_CMD, 32'h2);
      rd_chk("cmd", `TPG_ADDR_CMD, 32'h0, 1'b0);
      wr(`TPG_ADDR_CNT, 32'h1234);
      wr(`TPG_ADDR_STATUS, 32'h3);
      measure(60);
      chk_cnt("match0", 0, m0);
      chk_cnt("match1", 0, m1);
      rd_chk("count", `TPG_ADDR_CNT, 32'h0, 1'b0);
      rd_chk("status", `TPG_ADDR_STATUS, 32'h0, 1'b0);
      close_out();
   end
endmodule : tb_top
`default_nettype wire
